/* File: core/w_store_indirect_reset_exec.sv */
// Execution of direct/indirect W stores, no-operation and software reset
`timescale 1ns/1ps
`include "wsir_consts.svh"

module w_store_indirect_reset_exec #(
  parameter int PTR_W = `WSIR_PTR_W
) (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Decoded instruction
  input wire wsir_pkg::insn_t insn,
  // Software write of the reset-instruction flag
  input wire logic flag_set,
  // Data memory write
  output wsir_pkg::mem_wr_t mem_wr,
  // Pointer contents
  output logic [PTR_W-1:0] ptr0,
  output logic [PTR_W-1:0] ptr1,
  // Status and control outputs
  output logic reset_instruction_flag,
  output logic dev_reset_req,
  output logic retire
);
  import wsir_pkg::*;

  // Registered state
  logic [PTR_W-1:0] ptr_q [2]; // Both file-select pointers
  logic [PTR_W-1:0] ptr_d [2];
  mem_wr_t mem_wr_q, mem_wr_d; // Write issued last cycle
  logic soft_rst_q, soft_rst_d; // One-cycle device reset pulse
  logic flag_q, flag_d; // Reset-instruction flag
  logic retire_q, retire_d; // Instruction completed

  // Instruction taken: ignored while the device reset pulse is out
  logic take;
  logic [PTR_W-1:0] sel_ptr; // Pointer named by the instruction
  logic [PTR_W-1:0] ofs_ext; // Sign-extended offset
  assign take = insn.valid && !soft_rst_q;
  assign sel_ptr = ptr_q[insn.ptr_sel];
  assign ofs_ext = {{(PTR_W-6){insn.offset[5]}}, insn.offset};

  // Effective address and write request
  always_comb begin
    mem_wr_d = '0;
    mem_wr_d.data = insn.w_value;
    if (take) begin
      unique case (insn.op)
        OP_STORE_DIR: begin
          mem_wr_d.valid = 1'b1;
          // Window addresses own no storage; redirect through pointer
          if (insn.file_addr == `WSIR_WIN0_ADDR) begin
            mem_wr_d.addr = ptr_q[0];
          end else if (insn.file_addr == `WSIR_WIN1_ADDR) begin
            mem_wr_d.addr = ptr_q[1];
          end else begin
            mem_wr_d.addr = {{(PTR_W-7){1'b0}}, insn.file_addr};
          end
        end
        OP_STORE_IND: begin
          mem_wr_d.valid = 1'b1;
          unique case (insn.pointer_mode_field)
            `WSIR_MODE_PREINC: mem_wr_d.addr = sel_ptr + 16'h0001;
            `WSIR_MODE_PREDEC: mem_wr_d.addr = sel_ptr - 16'h0001;
            default: mem_wr_d.addr = sel_ptr;
          endcase
        end
        OP_STORE_OFS: begin
          mem_wr_d.valid = 1'b1;
          mem_wr_d.addr = sel_ptr + ofs_ext;
        end
        default: begin
          // No-operation and reset write nothing
          mem_wr_d.valid = 1'b0;
        end
      endcase
    end
  end

  // Write request register
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      mem_wr_q <= '0;
    end else begin
      mem_wr_q <= mem_wr_d;
    end
  end

  // Per-pointer update; an indirect store moves only the selected pointer
  for (genvar i = 0; i < 2; i++) begin : g_ptr
    logic hit; // This pointer is the one named
    logic [6:0] lo_addr; // Direct-store address of low byte
    logic [6:0] hi_addr; // Direct-store address of high byte
    assign hit = (insn.ptr_sel == 1'(i));
    assign lo_addr = (i == 0) ? `WSIR_PTR0_LO_ADDR : `WSIR_PTR1_LO_ADDR;
    assign hi_addr = (i == 0) ? `WSIR_PTR0_HI_ADDR : `WSIR_PTR1_HI_ADDR;

    // Next pointer value
    always_comb begin
      ptr_d[i] = ptr_q[i];
      if (soft_rst_q) begin
        ptr_d[i] = `WSIR_PTR_RESET;
      end else if (take && insn.op == OP_STORE_IND && hit) begin
        // Wrap is natural modulo 2^16; no status bit is produced
        if (insn.pointer_mode_field[0]) begin
          ptr_d[i] = ptr_q[i] - 16'h0001;
        end else begin
          ptr_d[i] = ptr_q[i] + 16'h0001;
        end
      end else if (take && insn.op == OP_STORE_DIR) begin
        // Pointer bytes are themselves file registers
        if (insn.file_addr == lo_addr) begin
          ptr_d[i][7:0] = insn.w_value;
        end else if (insn.file_addr == hi_addr) begin
          ptr_d[i][15:8] = insn.w_value;
        end
      end
    end

    // Pointer register
    always_ff @(posedge clk) begin
      if (sys_rst) begin
        ptr_q[i] <= `WSIR_PTR_RESET;
      end else begin
        ptr_q[i] <= ptr_d[i];
      end
    end
  end

  // Reset pulse, flag and retire
  always_comb begin
    soft_rst_d = take && insn.op == OP_SOFT_RESET;
    retire_d = take && insn.op != OP_NONE;
    flag_d = flag_q;
    // Clearing wins: the cause must be visible after the reset
    if (soft_rst_d) begin
      flag_d = 1'b0;
    end else if (flag_set) begin
      flag_d = 1'b1;
    end
  end

  // Flag survives the device reset it causes; only sys_rst presets it
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      soft_rst_q <= 1'b0;
      retire_q <= 1'b0;
      flag_q <= `WSIR_FLAG_RESET;
    end else begin
      soft_rst_q <= soft_rst_d;
      retire_q <= retire_d;
      flag_q <= flag_d;
    end
  end

  // Outputs
  assign mem_wr = mem_wr_q;
  assign ptr0 = ptr_q[0];
  assign ptr1 = ptr_q[1];
  assign reset_instruction_flag = flag_q;
  assign dev_reset_req = soft_rst_q;
  assign retire = retire_q;

  // Helper views for checks
  logic is_dir, is_ind, is_ofs, is_noop, is_rst;
  assign is_dir = take && insn.op == OP_STORE_DIR;
  assign is_ind = take && insn.op == OP_STORE_IND;
  assign is_ofs = take && insn.op == OP_STORE_OFS;
  assign is_noop = take && insn.op == OP_NO_OPERATION;
  assign is_rst = take && insn.op == OP_SOFT_RESET;
  logic [6:0] faddr;
  logic [7:0] wval;
  logic [1:0] pmode;
  logic psel;
  assign faddr = insn.file_addr;
  assign wval = insn.w_value;
  assign pmode = insn.pointer_mode_field;
  assign psel = insn.ptr_sel;

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  direct_store_a: assert property (
    is_dir && faddr > 7'h01 |=> mem_wr_q.valid && mem_wr_q.addr == {9'h000, $past(faddr)}
      && mem_wr_q.data == $past(wval))
    else $error("direct store address or data wrong");
  window_redirect_a: assert property (
    is_dir && faddr == 7'h01 |=> mem_wr_q.addr == $past(ptr_q[1]))
    else $error("window store not redirected");
  pre_addr_a: assert property (
    is_ind && pmode == 2'h1 |=> mem_wr_q.addr == $past(sel_ptr) - 16'h0001
      && mem_wr_q.data == $past(wval))
    else $error("predecrement address wrong");
  post_addr_a: assert property (
    is_ind && pmode == 2'h2 |=> mem_wr_q.addr == $past(sel_ptr))
    else $error("postincrement address wrong");
  offset_form_a: assert property (
    is_ofs && psel == 1'b0 |=> mem_wr_q.addr == $past(ptr_q[0]) + $past(ofs_ext)
      && ptr_q[0] == $past(ptr_q[0]))
    else $error("offset store wrong");
  ptr_step_a: assert property (
    is_ind && psel == 1'b0 && pmode[0] |=> ptr_q[0] == $past(ptr_q[0]) - 16'h0001)
    else $error("pointer not decremented");
  ptr_wrap_a: assert property (
    is_ind && psel == 1'b1 && !pmode[0] && ptr_q[1] == 16'hFFFF |=> ptr_q[1] == 16'h0000)
    else $error("pointer did not wrap");
  other_ptr_a: assert property (
    is_ind && psel == 1'b0 |=> ptr_q[1] == $past(ptr_q[1]))
    else $error("unselected pointer moved");
  soft_reset_a: assert property (
    is_rst |=> dev_reset_req && !reset_instruction_flag ##1 !dev_reset_req
      && ptr_q[0] == 16'h0000 && ptr_q[1] == 16'h0000)
    else $error("software reset sequence wrong");
  flag_clear_a: assert property (
    is_rst && flag_set |=> !reset_instruction_flag)
    else $error("reset flag not cleared");
  noop_quiet_a: assert property (
    is_noop |=> retire && !mem_wr_q.valid && ptr_q[0] == $past(ptr_q[0])
      && ptr_q[1] == $past(ptr_q[1]))
    else $error("no-operation changed state");

  // Main scenarios
  cov_ind_wrap_c: cover property (is_ind && ptr_q[0] == 16'hFFFF && psel == 1'b0);
  cov_ofs_neg_c: cover property (is_ofs && insn.offset[5]);
  cov_window_c: cover property (is_dir && faddr == 7'h00);
  cov_reset_c: cover property (is_rst ##2 is_ind);
endmodule // w_store_indirect_reset_exec

/* File: core/wsir_consts.svh */
// Constants for the working-register store, indirect store and reset executor
`ifndef WSIR_CONSTS_SVH
`define WSIR_CONSTS_SVH
`define WSIR_PTR_W 16
`define WSIR_FILE_MAX 7'h7F
`define WSIR_WIN0_ADDR 7'h00
`define WSIR_WIN1_ADDR 7'h01
`define WSIR_PTR0_LO_ADDR 7'h04
`define WSIR_PTR0_HI_ADDR 7'h05
`define WSIR_PTR1_LO_ADDR 7'h06
`define WSIR_PTR1_HI_ADDR 7'h07
`define WSIR_MODE_PREINC 2'h0
`define WSIR_MODE_PREDEC 2'h1
`define WSIR_MODE_POSTINC 2'h2
`define WSIR_MODE_POSTDEC 2'h3
`define WSIR_PTR_RESET 16'h0000
`define WSIR_FLAG_RESET 1'h1
`endif

/* File: core/wsir_pkg.sv */
// Types shared by the store / reset executor
package wsir_pkg;
  // Instruction kinds handled by this block
  typedef enum logic [2:0] {
    OP_NONE       = 3'h0,
    OP_STORE_DIR  = 3'h1,
    OP_STORE_IND  = 3'h2,
    OP_STORE_OFS  = 3'h3,
    OP_NO_OPERATION = 3'h4,
    OP_SOFT_RESET = 3'h5
  } op_t;

  // Decoded instruction from the decoder
  typedef struct packed {
    logic valid;
    op_t op;
    logic [6:0] file_addr;
    logic ptr_sel;
    logic [1:0] pointer_mode_field;
    logic [5:0] offset;
    logic [7:0] w_value;
  } insn_t;

  // Data memory write request
  typedef struct packed {
    logic valid;
    logic [15:0] addr;
    logic [7:0] data;
  } mem_wr_t;
endpackage

/* File: verif/w_store_indirect_reset_exec_bench.sv */
// Self-checking bench for the store / no-operation / software reset executor
`timescale 1ns/1ps

module w_store_indirect_reset_exec_bench;
  import wsir_pkg::*;
  // Clock, reset and design inputs
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  insn_t insn = '0;
  logic flag_set = 1'b0;
  insn_t rn = '0; // Random instruction under construction
  // Design outputs
  mem_wr_t mem_wr;
  logic [15:0] ptr0;
  logic [15:0] ptr1;
  logic reset_instruction_flag;
  logic dev_reset_req;
  logic retire;
  // Expected outputs after the next edge
  logic [15:0] e_p0 = 16'h0000;
  logic [15:0] e_p1 = 16'h0000;
  logic e_flag = 1'b1;
  logic e_rst = 1'b0;
  logic e_ret = 1'b0;
  logic e_wv = 1'b0;
  logic [15:0] e_wa = 16'h0000;
  logic [7:0] e_wd = 8'h00;
  logic [31:0] rnd = 32'hDCF13311; // Fixed seed keeps runs repeatable
  int err_count = 0;
  int samples_checked = 0;

  // 200 MHz clock
  always #2.5 clk = ~clk;

  w_store_indirect_reset_exec #(.PTR_W(16)) w_store_indirect_reset_exec_i (
    .clk(clk),
    .sys_rst(sys_rst),
    .insn(insn),
    .flag_set(flag_set),
    .mem_wr(mem_wr),
    .ptr0(ptr0),
    .ptr1(ptr1),
    .reset_instruction_flag(reset_instruction_flag),
    .dev_reset_req(dev_reset_req),
    .retire(retire)
  );

  // Galois shift register, next random word
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], 1'b0} ^ (x[31] ? 32'h04C11DB7 : 32'h00000000);
  endfunction

  // Build a valid decoded instruction
  function automatic insn_t mk(input logic [2:0] op, input logic [6:0] fa, input logic sel,
                               input logic [1:0] md, input logic [5:0] ofs, input logic [7:0] w);
    return {1'b1, op, fa, sel, md, ofs, w};
  endfunction

  // Compare one value, count it, report a difference
  task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // Reference behaviour: effect of instruction n taken at the next edge
  task automatic model(input insn_t n, input logic fset);
    logic [15:0] p;
    e_wv = 1'b0;
    e_ret = 1'b0;
    e_flag = e_flag | fset;
    p = n.ptr_sel ? e_p1 : e_p0;
    if (e_rst) begin
      // Reset cycle drops the instruction and clears both pointers
      e_p0 = 16'h0000;
      e_p1 = 16'h0000;
      e_rst = 1'b0;
    end else if (n.valid) begin
      e_ret = (n.op != OP_NONE);
      e_wd = n.w_value;
      case (n.op)
        OP_STORE_DIR: begin
          e_wv = 1'b1;
          // Window addresses redirect through the pointers
          e_wa = (n.file_addr == 7'h00) ? e_p0 : (n.file_addr == 7'h01) ? e_p1 :
                 {9'h000, n.file_addr};
          case (n.file_addr)
            7'h04: e_p0[7:0] = n.w_value;
            7'h05: e_p0[15:8] = n.w_value;
            7'h06: e_p1[7:0] = n.w_value;
            7'h07: e_p1[15:8] = n.w_value;
            default: ;
          endcase
        end
        OP_STORE_IND: begin
          e_wv = 1'b1;
          e_wa = (n.pointer_mode_field == 2'h0) ? p + 16'h0001 :
                 (n.pointer_mode_field == 2'h1) ? p - 16'h0001 : p;
          p = n.pointer_mode_field[0] ? p - 16'h0001 : p + 16'h0001;
          if (n.ptr_sel) e_p1 = p;
          else e_p0 = p;
        end
        OP_STORE_OFS: begin
          e_wv = 1'b1;
          e_wa = p + {{10{n.offset[5]}}, n.offset};
        end
        OP_SOFT_RESET: begin
          // Clear wins over a simultaneous software set
          e_rst = 1'b1;
          e_flag = 1'b0;
        end
        default: ;
      endcase
    end
  endtask

  // Drive one instruction, check the previous one's results
  task automatic step(input insn_t n, input logic fset);
    @(posedge clk);
    insn <= n;
    flag_set <= fset;
    #1;
    chk("retire", 16'(retire), 16'(e_ret));
    chk("reset request", 16'(dev_reset_req), 16'(e_rst));
    chk("flag", 16'(reset_instruction_flag), 16'(e_flag));
    chk("pointer 0", ptr0, e_p0);
    chk("pointer 1", ptr1, e_p1);
    chk("write valid", 16'(mem_wr.valid), 16'(e_wv));
    if (e_wv) begin
      chk("write address", mem_wr.addr, e_wa);
      chk("write data", 16'(mem_wr.data), 16'(e_wd));
    end
    model(n, fset);
  endtask

  // Verdict and end of run
  task automatic end_of_test;
    if (err_count == 0 && samples_checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  // Main sequence: corner cases, then random traffic
  initial begin
    repeat (16) @(posedge clk);
    sys_rst <= 1'b0;
    step(mk(3'h1, 7'h04, 1'b0, 2'h0, 6'h00, 8'hFF), 1'b0);
    step(mk(3'h1, 7'h05, 1'b0, 2'h0, 6'h00, 8'hFF), 1'b0);
    step(mk(3'h2, 7'h00, 1'b0, 2'h0, 6'h00, 8'h11), 1'b0);
    step(mk(3'h2, 7'h00, 1'b0, 2'h1, 6'h00, 8'h22), 1'b0);
    step(mk(3'h1, 7'h00, 1'b0, 2'h0, 6'h00, 8'h5A), 1'b0);
    step(mk(3'h1, 7'h7F, 1'b1, 2'h0, 6'h00, 8'h4F), 1'b0);
    step(mk(3'h3, 7'h00, 1'b1, 2'h0, 6'h20, 8'h33), 1'b0);
    step(mk(3'h3, 7'h00, 1'b1, 2'h3, 6'h1F, 8'h44), 1'b0);
    step(mk(3'h4, 7'h04, 1'b0, 2'h0, 6'h00, 8'h99), 1'b0);
    for (int m = 0; m < 4; m++) step(mk(3'h2, 7'h00, 1'b1, m[1:0], 6'h00, 8'hA0), 1'b0);
    // Second pointer below zero and back over the top
    step(mk(3'h2, 7'h00, 1'b1, 2'h1, 6'h00, 8'hA1), 1'b0);
    step(mk(3'h2, 7'h00, 1'b1, 2'h0, 6'h00, 8'hA2), 1'b0);
    step(mk(3'h5, 7'h00, 1'b0, 2'h0, 6'h00, 8'h00), 1'b1);
    step(mk(3'h1, 7'h20, 1'b0, 2'h0, 6'h00, 8'h4F), 1'b0);
    step('0, 1'b1);
    for (int i = 0; i < 3000; i++) begin
      rnd = lfsr(rnd);
      rn = mk((rnd[2:0] > 3'h5) ? rnd[2:0] - 3'h5 : rnd[2:0], rnd[9:3], rnd[10],
              rnd[12:11], rnd[18:13], rnd[26:19]);
      rn.valid = rnd[31] | rnd[30];
      step(rn, rnd[29] & rnd[28] & rnd[27]);
    end
    // Second reset in mid-run: the flag cleared by software comes back set
    step(mk(3'h5, 7'h00, 1'b0, 2'h0, 6'h00, 8'h00), 1'b0);
    step('0, 1'b0);
    @(posedge clk);
    sys_rst <= 1'b1;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    // Reset values seen at the first edge after release
    e_p0 = 16'h0000;
    e_p1 = 16'h0000;
    e_flag = 1'b1;
    e_rst = 1'b0;
    e_ret = 1'b0;
    e_wv = 1'b0;
    step('0, 1'b0);
    step('0, 1'b0);
    end_of_test();
  end
endmodule // w_store_indirect_reset_exec_bench
